//--- verification/ptpiq_host_mem.sv
`default_nettype none

// ****************************************
// Host memory model behind entry writes
// ****************************************
module ptpiq_host_mem (
	input  wire logic        clk_sys,      // System clock
	input  wire logic        nrst,         // Async reset, active low
	input  wire logic        mem_wr_valid, // Entry write offered
	input  wire logic [31:0] mem_wr_addr,  // Entry address
	input  wire logic [31:0] mem_wr_data,  // Entry word
	input  wire logic        hold_off,     // Bench forces a stall
	output var  logic        mem_wr_ready  // Memory takes the word
);
	timeunit 1ns;
	timeprecision 1ps;

	integer seed = 14;
	logic   nxt;

	initial mem_wr_ready = 1'b0;

	// Ready is picked at the edge, shown just after it; entries are never waited on
	always @(posedge clk_sys)
	begin
		nxt = nrst && !hold_off && 1'($random(seed));
		#1 mem_wr_ready = nxt;
	end
endmodule : ptpiq_host_mem

`default_nettype wire

//--- verification/ptpiq_top_chk.sv
`default_nettype none

// ****************************************
// Port checker for the probe and queue block
// ****************************************
module ptpiq_top_chk (
	input wire logic        clk_sys,              // System clock
	input wire logic        nrst,                 // Async reset, active low
	input wire logic        reg_wr,               // Write strobe
	input wire logic        reg_rd,               // Read strobe
	input wire logic [7:0]  reg_addr,             // Byte offset
	input wire logic [31:0] reg_wdata,            // Write data
	input wire logic [31:0] reg_rdata,            // Read data
	input wire logic        reg_rvalid,           // Read valid
	input wire logic        probe_req_valid,      // Probe request
	input wire logic        probe_req_ready,      // Probe taken
	input wire logic [4:0]  probe_req_ch,         // Probe channel
	input wire logic [31:0] config_block_pointer, // Pointer value
	input wire logic        irq_area_update_flag, // Pointer reload
	input wire logic        evt_ready,            // Buffer room
	input wire logic        mem_wr_valid,         // Entry write
	input wire logic        mem_wr_ready,         // Entry taken
	input wire logic [31:0] mem_wr_addr,          // Entry address
	input wire logic [31:0] mem_wr_data,          // Entry word
	input wire logic        host_irq_pulse        // Host interrupt
);
	timeunit 1ns;
	timeprecision 1ps;

	logic rd_d;
	logic take_d;
	logic unmapped;
	logic ptr_wr;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	// Offsets outside the six registers must read back as zero
	assign unmapped = !(reg_addr inside {ptpiq_pkg::OFF_CFG_PTR, ptpiq_pkg::OFF_PROBE,
		ptpiq_pkg::OFF_TXQ_BAS, ptpiq_pkg::OFF_TXQ_SIZ, ptpiq_pkg::OFF_RXQ_BAS,
		ptpiq_pkg::OFF_RXQ_SIZ});
	assign ptr_wr = reg_wr && (reg_addr == ptpiq_pkg::OFF_CFG_PTR);

	// Last cycle's read strobe and accepted entry write
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			{rd_d, take_d} <= 2'b00;
		else
			{rd_d, take_d} <= {reg_rd, mem_wr_valid && mem_wr_ready};

	sequence s_mem_stall;
		mem_wr_valid && !mem_wr_ready && !irq_area_update_flag;
	endsequence
	sequence s_mem_take;
		mem_wr_valid && mem_wr_ready;
	endsequence

	a_rd_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read strobe got no valid pulse");
	a_rvalid_cause: assert property (reg_rvalid |-> rd_d)
		else $error("read valid without a read");
	a_rdata_hold: assert property (!rd_d |-> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (reg_rd && unmapped |=> reg_rdata == 32'h0000_0000)
		else $error("unmapped offset read nonzero");
	a_ptr_update: assert property (ptr_wr |=>
		config_block_pointer == ($past(reg_wdata) & ptpiq_pkg::BASE_MASK))
		else $error("pointer register took wrong value");
	a_ptr_keep: assert property (!ptr_wr |=> $stable(config_block_pointer))
		else $error("pointer register changed without a write");
	a_mem_hold: assert property (s_mem_stall |=>
		mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data))
		else $error("entry write dropped or changed while stalled");
	a_addr_align: assert property (mem_wr_valid |-> mem_wr_addr[1:0] == 2'b00)
		else $error("entry address not word aligned");
	a_irq_cause: assert property (host_irq_pulse |-> take_d)
		else $error("interrupt without a written entry");
	a_probe_hold: assert property (probe_req_valid && !probe_req_ready |=>
		probe_req_valid && $stable(probe_req_ch))
		else $error("probe request dropped or changed");
	a_full_ready: assert property (!evt_ready |-> mem_wr_valid)
		else $error("buffer refused while empty");

	c_stall_take: cover property (s_mem_stall ##1 s_mem_take);
endmodule : ptpiq_top_chk

`default_nettype wire

//--- verification/ptpiq_top_tb.sv
`default_nettype none

// ****************************************
// Bench for the probe scheduler and event queues
// ****************************************
module ptpiq_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys = 1'b0;
	logic        nrst, reg_wr, reg_rd, reg_rvalid, slow_probe_select, hold_probe_select;
	logic        tx_sync, slot_valid, probe_done, probe_hold, probe_req_valid, probe_req_ready;
	logic        irq_area_update_flag, evt_valid, evt_ready, mem_wr_valid, mem_wr_ready;
	logic        host_irq_pulse, hold_off, irq_exp;
	logic [4:0]  slot_ch, probe_done_ch, probe_req_ch;
	logic [7:0]  reg_addr, siz[2];
	logic [31:0] reg_wdata, reg_rdata, config_block_pointer, mem_wr_addr, mem_wr_data, d, v;
	logic [31:0] bas[2];
	int          k[2];
	logic [4:0]  probe_q[$];
	integer      seed = 14;
	int          error_cnt = 0;
	int          cmp_count = 0;
	ptpiq_pkg::ptpiq_entry_t evt_entry, h, exp_q[$];

	// Every port meets the bench signal of the same name
	ptpiq_top u_ptpiq_top (.*);

	ptpiq_host_mem u_ptpiq_host_mem (.*);

	// Clock and a DMA side that takes probe requests at random
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) #1 probe_req_ready = 1'($random(seed));

	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask : tick

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic give_verdict;
		if (error_cnt == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	task automatic wr(input logic [7:0] a, input logic [31:0] val);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = val;
		tick();
		reg_wr = 1'b0;
		tick();
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] val);
		reg_rd = 1'b1;
		reg_addr = a;
		tick();
		reg_rd = 1'b0;
		chk(32'(reg_rvalid), 32'h0000_0001);
		val = reg_rdata;
		tick();
	endtask : rd

	// Kind 0 is a descriptor check result, 1 a time slot, 2 a frame sync
	task automatic pulse(input int kind, input logic [4:0] ch, input logic hld);
		probe_done = (kind == 0);
		slot_valid = (kind == 1);
		tx_sync = (kind == 2);
		probe_done_ch = ch;
		slot_ch = ch;
		probe_hold = hld;
		tick();
		{probe_done, slot_valid, tx_sync} = 3'b000;
		tick();
	endtask : pulse

	task automatic expect_probes(input int n, input logic [4:0] a, input logic [4:0] b);
		repeat (16) tick();
		chk(32'(probe_q.size()), 32'(n));
		if (n > 0)
			chk(32'(probe_q[0]), 32'(a));
		if (n > 1)
			chk(32'(probe_q[1]), 32'(b));
		probe_q.delete();
	endtask : expect_probes

	// Offer one entry and hold it until the buffer takes it
	task automatic push(input ptpiq_pkg::ptpiq_entry_t ent);
		evt_valid = 1'b1;
		evt_entry = ent;
		for (int i = 0; i < 200 && evt_ready !== 1'b1; i++)
			tick();
		exp_q.push_back(ent);
		tick();
	endtask : push

	task automatic drain;
		evt_valid = 1'b0;
		for (int i = 0; i < 400 && exp_q.size() > 0; i++)
			tick();
		repeat (2) tick();
	endtask : drain

	task automatic reload;
		irq_area_update_flag = 1'b1;
		k[0] = 0;
		k[1] = 0;
		tick();
		irq_area_update_flag = 1'b0;
		tick();
	endtask : reload

	function automatic ptpiq_pkg::ptpiq_entry_t rnd();
		return 34'({$random(seed), $random(seed)});
	endfunction : rnd

	function automatic logic [31:0] msk(input int i);
		return (i == 1) ? 32'hffff_ffff : (i % 2 == 0) ? ptpiq_pkg::BASE_MASK : ptpiq_pkg::SIZE_MASK;
	endfunction : msk

	function automatic logic [4:0] slow_ch(input int frame, input int grp);
		return 5'(frame + grp * ptpiq_pkg::SLOW_DIV);
	endfunction : slow_ch

	// Sampled mid-cycle, so values are those the next rising edge will see
	always @(negedge clk_sys)
	begin
		if (nrst)
			chk(32'(host_irq_pulse), 32'(irq_exp));
		irq_exp = 1'b0;
		if (nrst && probe_req_valid && probe_req_ready)
			probe_q.push_back(probe_req_ch);
		if (nrst && mem_wr_valid && mem_wr_ready)
		begin
			h = exp_q.pop_front();
			chk(mem_wr_addr, bas[h.is_tx] + 32'(k[h.is_tx]) * ptpiq_pkg::DWORD_BYTES);
			chk(mem_wr_data, h.data);
			k[h.is_tx] = (k[h.is_tx] + 1) % ((int'(siz[h.is_tx]) + 1) * 16);
			irq_exp = h.irq_en;
		end
	end

	// Watchdog, well beyond the few hundred cycles the run needs
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		give_verdict();
	end

	initial
	begin
		{reg_wr, reg_rd, reg_addr, reg_wdata, slow_probe_select, hold_probe_select} = '0;
		{tx_sync, slot_valid, slot_ch, probe_done, probe_done_ch, probe_hold} = '0;
		{irq_area_update_flag, evt_valid, evt_entry, hold_off, irq_exp, probe_req_ready} = '0;
		k[0] = 0;
		k[1] = 0;
		nrst = 1'b0;
		repeat (5) @(posedge clk_sys);
		#1 nrst = 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			rd(8'h28 + 8'(4 * i), d);
			chk(d, ptpiq_pkg::REG_RESET);
		end
		wr(ptpiq_pkg::OFF_PROBE, 32'hffff_ffff);
		pulse(0, 5'd2, 1'b1);
		pulse(0, 5'd10, 1'b1);
		expect_probes(0, 5'd0, 5'd0);
		wr(ptpiq_pkg::OFF_PROBE, 32'hffff_fff7);
		expect_probes(1, 5'd3, 5'd0);
		pulse(0, 5'd3, 1'b1);
		expect_probes(0, 5'd0, 5'd0);
		slow_probe_select = 1'b1;
		repeat (3) pulse(2, 5'd0, 1'b0);
		expect_probes(2, slow_ch(2, 0), slow_ch(2, 1));
		slow_probe_select = 0;
		hold_probe_select = 1'b1;
		wr(ptpiq_pkg::OFF_PROBE, 32'hffff_ff77);
		pulse(0, 5'd7, 1'b1);
		expect_probes(1, 5'd7, 5'd0);
		pulse(1, 5'd7, 1'b0);
		pulse(1, 5'd9, 1'b0);
		expect_probes(1, 5'd7, 5'd0);
		hold_probe_select = 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			v = $random(seed);
			wr(8'h28 + 8'(4 * i), v);
			rd(8'h28 + 8'(4 * i), d);
			chk(d, v & msk(i));
		end
		wr(8'h40, 32'h5a5a_a5a5);
		rd(8'h40, d);
		chk(d, 32'h0000_0000);
		bas[1] = $random(seed) & ptpiq_pkg::BASE_MASK;
		bas[0] = $random(seed) & ptpiq_pkg::BASE_MASK;
		siz[1] = 8'h00;
		siz[0] = 8'h01;
		wr(ptpiq_pkg::OFF_TXQ_BAS, bas[1]);
		wr(ptpiq_pkg::OFF_TXQ_SIZ, {24'h00_0000, siz[1]});
		wr(ptpiq_pkg::OFF_RXQ_BAS, bas[0]);
		wr(ptpiq_pkg::OFF_RXQ_SIZ, {24'h00_0000, siz[0]});
		reload();
		hold_off = 1'b1;
		push(rnd());
		push(rnd());
		chk(32'(evt_ready), 32'h0000_0000);
		hold_off = 1'b0;
		repeat (70) push(rnd());
		drain();
		bas[0] = $random(seed) & ptpiq_pkg::BASE_MASK;
		wr(ptpiq_pkg::OFF_RXQ_BAS, bas[0]);
		reload();
		repeat (20) push(rnd());
		drain();
		give_verdict();
	end
endmodule : ptpiq_top_tb

// Checker ports carry the names of the top's own ports
bind ptpiq_top ptpiq_top_chk u_ptpiq_top_chk (.*);

`default_nettype wire

//--- verilog/ptpiq_fifo2.sv
`default_nettype none

module ptpiq_fifo2 (
	input  wire logic                 clk_sys,   // System clock
	input  wire logic                 nrst,      // Async reset, active low
	input  wire logic                 in_valid,  // Entry offered
	output logic                      in_ready,  // Room for an entry
	input  wire ptpiq_pkg::ptpiq_entry_t in_data, // Entry in
	output logic                      out_valid, // Entry available
	input  wire logic                 out_ready, // Drain accepts
	output ptpiq_pkg::ptpiq_entry_t   out_data   // Oldest entry
);

	// ************************************************************
	// Two slots, pointers and fill count
	// ************************************************************
	ptpiq_pkg::ptpiq_entry_t slot_r [2];
	logic       wr_ptr_r;
	logic       rd_ptr_r;
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	wire        push = in_valid & in_ready;
	wire        pop  = out_valid & out_ready;

	// Full and empty straight from the count, so back-pressure is exact
	assign in_ready  = (cnt_r != 2'd2);
	assign out_valid = (cnt_r != 2'd0);
	assign out_data  = slot_r[rd_ptr_r];
	assign cnt_nxt   = cnt_r + {1'b0, push} - {1'b0, pop};

	// Storage has no reset; the count guards it
	always_ff @(posedge clk_sys)
	begin
		if (push)
			slot_r[wr_ptr_r] <= in_data;
	end

	// Pointer and count update
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			cnt_r    <= 2'd0;
		end
		else
		begin
			wr_ptr_r <= wr_ptr_r ^ push;
			rd_ptr_r <= rd_ptr_r ^ pop;
			cnt_r    <= cnt_nxt;
		end
	end

endmodule : ptpiq_fifo2

`default_nettype wire

//--- verilog/ptpiq_pkg.sv
`default_nettype none

package ptpiq_pkg;

	// ************************************************************
	// Register map and field layout
	// ************************************************************
	localparam int unsigned REG_W       = 32;
	localparam int unsigned ADDR_W      = 8;
	localparam logic [7:0]  OFF_CFG_PTR = 8'h28;
	localparam logic [7:0]  OFF_PROBE   = 8'h2c;
	localparam logic [7:0]  OFF_TXQ_BAS = 8'h30;
	localparam logic [7:0]  OFF_TXQ_SIZ = 8'h34;
	localparam logic [7:0]  OFF_RXQ_BAS = 8'h38;
	localparam logic [7:0]  OFF_RXQ_SIZ = 8'h3c;

	// Base registers drop the two byte bits, size registers keep eight bits
	localparam logic [31:0] BASE_MASK   = 32'hffff_fffc;
	localparam logic [31:0] SIZE_MASK   = 32'h0000_00ff;
	localparam int unsigned SIZE_W      = 8;
	localparam logic [31:0] REG_RESET   = 32'h0000_0000;

	// ************************************************************
	// Channels, slow probing and queue geometry
	// ************************************************************
	localparam int unsigned CH_NUM      = 32;
	localparam int unsigned CH_W        = 5;
	localparam int unsigned SLOW_DIV    = 8;
	localparam int unsigned FRAME_W     = 3;
	localparam int unsigned GROUP_NUM   = CH_NUM / SLOW_DIV;
	localparam int unsigned QOFF_W      = 12;
	localparam logic [3:0]  QUNIT_LAST  = 4'hf;
	localparam logic [31:0] DWORD_BYTES = 32'h0000_0004;
	localparam logic [QOFF_W-1:0] QOFF_ZERO = 12'h000;
	localparam logic [QOFF_W-1:0] QOFF_ONE  = 12'h001;

	// One status entry on its way to an event queue
	typedef struct packed {
		logic        is_tx;
		logic        irq_en;
		logic [31:0] data;
	} ptpiq_entry_t;

	localparam int unsigned ENTRY_W = $bits(ptpiq_entry_t);

endpackage : ptpiq_pkg

`default_nettype wire

//--- verilog/ptpiq_qptr.sv
`default_nettype none

module ptpiq_qptr (
	input  wire logic        clk_sys, // System clock
	input  wire logic        nrst,    // Async reset, active low
	input  wire logic [31:0] base,    // Queue start address
	input  wire logic [7:0]  size_n,  // Queue size code
	input  wire logic        reload,  // Restart at base
	input  wire logic        advance, // One entry written
	output logic      [31:0] addr     // Next entry address
);

	// ************************************************************
	// Write pointer of one circular event queue
	// ************************************************************
	logic [11:0] off_r;
	logic [11:0] off_nxt;
	logic [31:0] addr_r;
	logic [31:0] addr_nxt;
	wire  [11:0] last_off = {size_n, ptpiq_pkg::QUNIT_LAST}; // R13
	wire         at_end   = (off_r == last_off);

	// Reload beats advance; the end wraps to base and overwrites old entries
	assign off_nxt  = reload ? ptpiq_pkg::QOFF_ZERO :
	                  !advance ? off_r :
	                  at_end ? ptpiq_pkg::QOFF_ZERO : off_r + ptpiq_pkg::QOFF_ONE; // R09
	assign addr_nxt = reload ? base :
	                  !advance ? addr_r :
	                  at_end ? base : addr_r + ptpiq_pkg::DWORD_BYTES; // R18
	assign addr     = addr_r;

	// Pointer registers
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			off_r  <= ptpiq_pkg::QOFF_ZERO;
			addr_r <= ptpiq_pkg::REG_RESET;
		end
		else
		begin
			off_r  <= off_nxt;
			addr_r <= addr_nxt;
		end
	end

endmodule : ptpiq_qptr

`default_nettype wire

//--- verilog/ptpiq_top.sv
// Overview of operation
// R01: Config block pointer register holds word-aligned address of block base pointer.
// R02: Probe mask holds one active-low probe bit per channel, thirty-two total.
// R03: Plain mode with hold seen: bit one stops, bit zero gives one probe.
// R04: Clearing a channel's probe bit triggers one single probe of that channel.
// R05: Bit set plus slow select with hold seen: probe at frame rate over eight.
// R06: Bit clear plus hold select: recheck hold every slot of that channel.
// R07: Software should avoid per-slot hold probing; it costs extra bus bandwidth.
// R08: Each event writes an entry, advances the queue pointer, interrupts unless masked.
// R09: Queue pointer at end wraps to start address and overwrites older entries.
// R10: Host software reads entries itself; device never waits for consumption.
// R11: Host changing queue base or size issues action request with update flag.
// R12: Transmit queue base register holds word-aligned transmit queue start address.
// R13: Size code n gives (n+1)*16 words per queue, at most 4096 words.
// R14: Receive queue base register holds word-aligned receive queue start address.
// R15: Data status goes to separate like rx and tx queues; other status elsewhere.
// R16: Slow mode probes channels n, n+8, n+16, n+24 in frame n.
// R17: Base low two bits read zero, ignore writes; all six reset to zero.
// R18: Queue write pointers reload from base on accepted update action request.
`default_nettype none

module ptpiq_top (
	input  wire logic        clk_sys,              // System clock, 125 MHz
	input  wire logic        nrst,                 // Async reset, active low
	// Register access port
	input  wire logic        reg_wr,               // Register write strobe
	input  wire logic        reg_rd,               // Register read strobe
	input  wire logic [7:0]  reg_addr,             // Register byte offset
	input  wire logic [31:0] reg_wdata,            // Write data
	output logic      [31:0] reg_rdata,            // Read data, registered
	output logic             reg_rvalid,           // Read data valid pulse
	// Mode selections from the core option register
	input  wire logic        slow_probe_select,    // Slow probing chosen
	input  wire logic        hold_probe_select,    // Per-slot hold probing chosen
	// Transmit DMA side
	input  wire logic        tx_sync,              // Transmit frame sync pulse
	input  wire logic        slot_valid,           // Time slot strobe
	input  wire logic [4:0]  slot_ch,              // Channel owning the slot
	input  wire logic        probe_done,           // Descriptor check finished
	input  wire logic [4:0]  probe_done_ch,        // Channel checked
	input  wire logic        probe_hold,           // Hold flag was found set
	output logic             probe_req_valid,      // Probe request to DMA
	input  wire logic        probe_req_ready,      // DMA takes the request
	output logic      [4:0]  probe_req_ch,         // Channel to probe
	output logic      [31:0] config_block_pointer, // Pointer to control block base
	// Status entries from the core
	input  wire logic        irq_area_update_flag, // Accepted update action request
	input  wire logic        evt_valid,            // Status entry offered
	output logic             evt_ready,            // Entry accepted
	input  wire ptpiq_pkg::ptpiq_entry_t evt_entry, // Entry contents
	// Host memory write side
	output logic             mem_wr_valid,         // Entry write request
	input  wire logic        mem_wr_ready,         // Host memory takes it
	output logic      [31:0] mem_wr_addr,          // Entry host address
	output logic      [31:0] mem_wr_data,          // Entry word
	output logic             host_irq_pulse        // Host interrupt request pulse
);

	// ************************************************************
	// Register decode
	// ************************************************************
	logic [31:0] cfg_ptr_r;
	logic [31:0] probe_mask_r;
	logic [31:0] txq_base_r;
	logic [31:0] txq_size_r;
	logic [31:0] rxq_base_r;
	logic [31:0] rxq_size_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic        rvalid_r;

	// One hit wire per register
	wire hit_cfg   = (reg_addr == ptpiq_pkg::OFF_CFG_PTR);
	wire hit_probe = (reg_addr == ptpiq_pkg::OFF_PROBE);
	wire hit_txb   = (reg_addr == ptpiq_pkg::OFF_TXQ_BAS);
	wire hit_txs   = (reg_addr == ptpiq_pkg::OFF_TXQ_SIZ);
	wire hit_rxb   = (reg_addr == ptpiq_pkg::OFF_RXQ_BAS);
	wire hit_rxs   = (reg_addr == ptpiq_pkg::OFF_RXQ_SIZ);

	// Writes masked at the field: base low bits and upper size bits stay zero
	wire [31:0] base_wdata = reg_wdata & ptpiq_pkg::BASE_MASK; // R17
	wire [31:0] size_wdata = reg_wdata & ptpiq_pkg::SIZE_MASK; // R13

	wire [31:0] cfg_ptr_nxt    = (reg_wr & hit_cfg) ? base_wdata : cfg_ptr_r; // R01
	wire [31:0] probe_mask_nxt = (reg_wr & hit_probe) ? reg_wdata : probe_mask_r; // R02
	wire [31:0] txq_base_nxt   = (reg_wr & hit_txb) ? base_wdata : txq_base_r; // R12
	wire [31:0] txq_size_nxt   = (reg_wr & hit_txs) ? size_wdata : txq_size_r;
	wire [31:0] rxq_base_nxt   = (reg_wr & hit_rxb) ? base_wdata : rxq_base_r; // R14
	wire [31:0] rxq_size_nxt   = (reg_wr & hit_rxs) ? size_wdata : rxq_size_r;

	// Read mux; an unmapped offset reads as zero
	assign rdata_nxt = hit_cfg   ? cfg_ptr_r :
	                   hit_probe ? probe_mask_r :
	                   hit_txb   ? txq_base_r :
	                   hit_txs   ? txq_size_r :
	                   hit_rxb   ? rxq_base_r :
	                   hit_rxs   ? rxq_size_r : ptpiq_pkg::REG_RESET;

	// Register file, all cleared by reset
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			cfg_ptr_r    <= ptpiq_pkg::REG_RESET; // R17
			probe_mask_r <= ptpiq_pkg::REG_RESET;
			txq_base_r   <= ptpiq_pkg::REG_RESET;
			txq_size_r   <= ptpiq_pkg::REG_RESET;
			rxq_base_r   <= ptpiq_pkg::REG_RESET;
			rxq_size_r   <= ptpiq_pkg::REG_RESET;
		end
		else
		begin
			cfg_ptr_r    <= cfg_ptr_nxt;
			probe_mask_r <= probe_mask_nxt;
			txq_base_r   <= txq_base_nxt;
			txq_size_r   <= txq_size_nxt;
			rxq_base_r   <= rxq_base_nxt;
			rxq_size_r   <= rxq_size_nxt;
		end
	end

	// Read data held until the next read
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			rdata_r  <= ptpiq_pkg::REG_RESET;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rdata_r  <= reg_rd ? rdata_nxt : rdata_r;
			rvalid_r <= reg_rd;
		end
	end

	assign reg_rdata            = rdata_r;
	assign reg_rvalid           = rvalid_r;
	assign config_block_pointer = cfg_ptr_r;

	// ************************************************************
	// Per-channel idle tracking
	// ************************************************************
	logic [31:0] idle_r;
	logic [31:0] idle_nxt;
	logic [31:0] spent_r;
	logic [31:0] spent_nxt;
	logic [31:0] pend_r;
	logic [31:0] pend_nxt;
	logic [2:0]  frame_r;

	wire [31:0] done_oh    = 32'h0000_0001 << probe_done_ch;
	wire [31:0] slot_oh    = 32'h0000_0001 << slot_ch;
	wire        hold_seen  = probe_done & probe_hold;
	wire        resumed    = probe_done & !probe_hold;
	wire        done_bit   = probe_mask_r[probe_done_ch];
	wire        slot_bit   = probe_mask_r[slot_ch];

	// A channel is idle from a hold sighting until a check finds it free
	assign idle_nxt = (idle_r & ~({32{resumed}} & done_oh)) | ({32{hold_seen}} & done_oh);

	// ************************************************************
	// Probe scheduling
	// ************************************************************
	// Bits that software drives from one to zero by a write
	wire [31:0] cleared_bits = {32{reg_wr & hit_probe}} & probe_mask_r & ~reg_wdata;

	// Without hold probing, a zero bit grants one probe per idle spell
	wire set_single = hold_seen & !done_bit & !hold_probe_select & !spent_r[probe_done_ch]; // R03

	// A one bit without slow select leaves the channel alone, so no term here
	wire [31:0] single_set = {32{set_single}} & done_oh;

	// Slow probing: one group of four interleaved channels per frame
	wire [7:0]  frame_oh   = 8'h01 << frame_r;
	wire [31:0] slow_group = {ptpiq_pkg::GROUP_NUM{frame_oh}}; // R16
	wire [31:0] slow_set   = {32{tx_sync & slow_probe_select}} & slow_group
	                         & idle_r & probe_mask_r; // R05

	// Hold probing rechecks in each slot the channel owns; heavy on the bus
	wire [31:0] hold_set   = {32{slot_valid & hold_probe_select & !slot_bit}}
	                         & slot_oh & idle_r; // R06

	wire [31:0] pend_set   = single_set | cleared_bits | slow_set | hold_set; // R04

	// The once-only mark stays until the channel is seen running again
	assign spent_nxt = (spent_r & ~({32{resumed}} & done_oh)) | single_set | cleared_bits;

	// Lowest pending channel wins; fixed priority is fine at these rates
	function automatic logic [4:0] lowest_ch(input logic [31:0] vec);
		logic [4:0] idx;
		idx = 5'd0;
		for (int i = ptpiq_pkg::CH_NUM - 1; i >= 0; i--)
		begin
			if (vec[i])
				idx = i[4:0];
		end
		return idx;
	endfunction : lowest_ch

	logic        preq_valid_r;
	logic [4:0]  preq_ch_r;
	wire         preq_free  = !preq_valid_r | probe_req_ready;
	wire         pend_any   = |pend_r;
	wire         grant      = preq_free & pend_any;
	wire  [4:0]  grant_ch   = lowest_ch(pend_r);
	wire  [31:0] grant_oh   = {32{grant}} & (32'h0000_0001 << grant_ch);

	// A new request in the clearing cycle is kept: set wins over clear
	assign pend_nxt = (pend_r & ~grant_oh) | pend_set;

	// Frame divider for the slow probing rate
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			frame_r <= 3'd0;
		else if (tx_sync)
			frame_r <= frame_r + 3'd1; // R05
	end

	// Channel state registers
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			idle_r  <= 32'h0000_0000;
			spent_r <= 32'h0000_0000;
			pend_r  <= 32'h0000_0000;
		end
		else
		begin
			idle_r  <= idle_nxt;
			spent_r <= spent_nxt;
			pend_r  <= pend_nxt;
		end
	end

	// Probe request output, held until the DMA takes it
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			preq_valid_r <= 1'b0;
			preq_ch_r    <= 5'd0;
		end
		else if (preq_free)
		begin
			preq_valid_r <= pend_any;
			preq_ch_r    <= pend_any ? grant_ch : preq_ch_r;
		end
	end

	assign probe_req_valid = preq_valid_r;
	assign probe_req_ch    = preq_ch_r;

	// ************************************************************
	// Event queues in host memory
	// ************************************************************
	ptpiq_pkg::ptpiq_entry_t head;
	logic        head_valid;
	logic [31:0] txq_addr;
	logic [31:0] rxq_addr;
	logic        irq_r;

	// The buffer lets the memory side stall without dropping an entry
	ptpiq_fifo2 u_fifo (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.in_valid  (evt_valid),
		.in_ready  (evt_ready),
		.in_data   (evt_entry),
		.out_valid (head_valid),
		.out_ready (mem_wr_ready),
		.out_data  (head)
	);

	// Never waits on the host to consume; only memory acceptance gates it
	wire entry_done = head_valid & mem_wr_ready; // R10
	wire tx_adv     = entry_done & head.is_tx; // R15
	wire rx_adv     = entry_done & !head.is_tx;

	// Transmit queue pointer
	ptpiq_qptr u_txq (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.base    (txq_base_r),
		.size_n  (txq_size_r[7:0]),
		.reload  (irq_area_update_flag), // R18
		.advance (tx_adv), // R08
		.addr    (txq_addr)
	);

	// Receive queue pointer
	ptpiq_qptr u_rxq (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.base    (rxq_base_r),
		.size_n  (rxq_size_r[7:0]),
		.reload  (irq_area_update_flag), // R18
		.advance (rx_adv), // R08
		.addr    (rxq_addr)
	);

	// Address steered by direction; both sources are registers
	assign mem_wr_valid = head_valid;
	assign mem_wr_addr  = head.is_tx ? txq_addr : rxq_addr; // R15
	assign mem_wr_data  = head.data;

	// Interrupt raised after the entry lands, unless the event is masked
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			irq_r <= 1'b0;
		else
			irq_r <= entry_done & head.irq_en; // R08
	end

	assign host_irq_pulse = irq_r;

endmodule : ptpiq_top

`default_nettype wire
